// ---- rtl/fmoc_pkg.sv ----
// package: register map, field positions and reset values of the fault mask and output control bank
// Contract
// - enable low powers down output b; else control bit 6 decides.
// - enable low powers down output a; else control bit 5 decides.
// - mask bits 4..1 stop their termination-fault flag reaching the fault pin.
// - mask bit 0 stops the input-signal condition reaching the fault pin.
// - polarity bits 4..1 pick whether flag high or low pulls fault low.
// - polarity bit 0: zero faults on signal absent, one on signal present.
// - high-rate threshold a is output-a bits 7:5 plus polarity bit 7, default 1000.
// - polarity register bit 6 is the standard-rate threshold low bit for output a.
// - output-a bits 4:0 set drive amplitude in about 5 mV steps, default 10000.
// - mask bit 7 picks edge rate, one standard; high rate pin forces standard.
// - status flags: four termination faults in bits 4..1, signal present in bit 0.
package fmoc_pkg;

    // register offsets
    localparam logic [7:0] FMOC_OFF_MASK     = 8'h02;
    localparam logic [7:0] FMOC_OFF_POLARITY = 8'h03;
    localparam logic [7:0] FMOC_OFF_OUT_A    = 8'h04;

    // reset values
    localparam logic [7:0] FMOC_RST_MASK     = 8'h00;
    localparam logic [7:0] FMOC_RST_POLARITY = 8'h00;
    localparam logic [7:0] FMOC_RST_OUT_A    = 8'h90;

    // field positions, power and fault mask register
    localparam int FMOC_BIT_RATE_SEL   = 7;
    localparam int FMOC_BIT_PD_B       = 6;
    localparam int FMOC_BIT_PD_A       = 5;
    localparam int FMOC_BIT_COND_HI    = 4;
    localparam int FMOC_BIT_COND_LO    = 1;
    localparam int FMOC_BIT_SIGNAL     = 0;

    // field positions, polarity register
    localparam int FMOC_BIT_HI_THR_LSB = 7;
    localparam int FMOC_BIT_STD_THR_LSB = 6;
    localparam int FMOC_BIT_POL_RSVD   = 5;

    // field positions, output-a register
    localparam int FMOC_BIT_HI_THR_MSB = 7;
    localparam int FMOC_BIT_HI_THR_TOP = 5;
    localparam int FMOC_BIT_AMP_MSB    = 4;

    // all state of the bank
    typedef struct packed {
        logic [7:0] power_and_fault_mask;
        logic [7:0] fault_polarity_select;
        logic [7:0] out0_threshold_amplitude;
        logic       enable_meta;
        logic       enable_sync;
        logic       rate_pin_meta;
        logic       rate_pin_sync;
        logic       out0_power_down;
        logic       out1_power_down;
        logic       standard_def_rate_select;
        logic       fault_n;
        logic [7:0] reg_rdata;
    } fmoc_state_t;

endpackage : fmoc_pkg

// ---- rtl/fmoc_bank.sv ----
// fault mask, polarity and output-a control registers with fault pin combining
`timescale 1ns/1ps
module fmoc_bank (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // device pins
    input  wire logic       enable_pin,
    input  wire logic       rate_pin,
    // status flags from the status register, same clock
    input  wire logic [4:0] status_flags,
    // register port from the serial target engine
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // controls to the analog section
    output logic            out0_power_down,
    output logic            out1_power_down,
    output logic            standard_def_rate_select,
    output logic      [3:0] hi_rate_threshold_a,
    output logic            std_rate_threshold_a_low_bit,
    output logic      [4:0] out_a_level_code,
    // active-low fault pin
    output logic            fault_n
);
    import fmoc_pkg::*;

    fmoc_state_t state;
    fmoc_state_t next_state;
    logic [4:0]  cond_active;

    // one active term per termination-fault flag
    genvar gi;
    generate
        for (gi = FMOC_BIT_COND_LO; gi <= FMOC_BIT_COND_HI; gi++) begin : g_term
            // polarity one inverts the flag before masking
            assign cond_active[gi] = ~state.power_and_fault_mask[gi]
                                   & (status_flags[gi] ^ state.fault_polarity_select[gi]);
        end
    endgenerate

    // signal condition: polarity zero faults on absence, one on presence
    assign cond_active[FMOC_BIT_SIGNAL] = ~state.power_and_fault_mask[FMOC_BIT_SIGNAL]
        & ~(status_flags[FMOC_BIT_SIGNAL] ^ state.fault_polarity_select[FMOC_BIT_SIGNAL]);

    // next-state logic for the whole bank
    always_comb begin
        next_state = state;
        // pins come from outside the clock domain, two flops before use
        next_state.enable_meta   = enable_pin;
        next_state.enable_sync   = state.enable_meta;
        next_state.rate_pin_meta = rate_pin;
        next_state.rate_pin_sync = state.rate_pin_meta;
        // register writes
        if (reg_wr) begin
            case (reg_addr)
                FMOC_OFF_MASK: begin
                    next_state.power_and_fault_mask = reg_wdata;
                end
                FMOC_OFF_POLARITY: begin
                    // reserved bit kept at zero even if the host slips
                    next_state.fault_polarity_select = reg_wdata;
                    next_state.fault_polarity_select[FMOC_BIT_POL_RSVD] = 1'b0;
                end
                FMOC_OFF_OUT_A: begin
                    next_state.out0_threshold_amplitude = reg_wdata;
                end
                default: begin
                    next_state.reg_rdata = state.reg_rdata;
                end
            endcase
        end
        // register reads, unmapped offsets answer zero
        if (reg_rd) begin
            case (reg_addr)
                FMOC_OFF_MASK:     next_state.reg_rdata = state.power_and_fault_mask;
                FMOC_OFF_POLARITY: next_state.reg_rdata = state.fault_polarity_select;
                FMOC_OFF_OUT_A:    next_state.reg_rdata = state.out0_threshold_amplitude;
                default:           next_state.reg_rdata = 8'h00;
            endcase
        end
        // pin low overrides the power-down bits
        next_state.out1_power_down = ~state.enable_sync
                                   | state.power_and_fault_mask[FMOC_BIT_PD_B];
        next_state.out0_power_down = ~state.enable_sync
                                   | state.power_and_fault_mask[FMOC_BIT_PD_A];
        // rate pin high forces standard rate
        next_state.standard_def_rate_select = state.rate_pin_sync
                                            | state.power_and_fault_mask[FMOC_BIT_RATE_SEL];
        // registered so the pin never glitches between terms
        next_state.fault_n = ~(|cond_active);
    end

    // state register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state                          <= '0;
            state.power_and_fault_mask     <= FMOC_RST_MASK;
            state.fault_polarity_select    <= FMOC_RST_POLARITY;
            state.out0_threshold_amplitude <= FMOC_RST_OUT_A;
            state.out0_power_down          <= 1'b1;
            state.out1_power_down          <= 1'b1;
            state.fault_n                  <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    // outputs
    assign reg_rdata                    = state.reg_rdata;
    assign out0_power_down              = state.out0_power_down;
    assign out1_power_down              = state.out1_power_down;
    assign standard_def_rate_select     = state.standard_def_rate_select;
    assign fault_n                      = state.fault_n;
    // threshold joins three upper bits with the low bit from the polarity register
    assign hi_rate_threshold_a = {state.out0_threshold_amplitude[FMOC_BIT_HI_THR_MSB:FMOC_BIT_HI_THR_TOP],
                                  state.fault_polarity_select[FMOC_BIT_HI_THR_LSB]};
    assign std_rate_threshold_a_low_bit = state.fault_polarity_select[FMOC_BIT_STD_THR_LSB];
    assign out_a_level_code = state.out0_threshold_amplitude[FMOC_BIT_AMP_MSB:0];

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_enable_low_held;
        (!enable_pin)[*4];
    endsequence

    sequence s_mask_write(logic [7:0] off);
        reg_wr && reg_addr == off;
    endsequence

    chk_pd_b_enable: assert property (s_enable_low_held |-> out1_power_down)
        else $error("output b not powered down with enable low");
    chk_pd_a_enable: assert property (s_enable_low_held |-> out0_power_down)
        else $error("output a not powered down with enable low");
    // output a follows its bit once the enable pin has settled high
    chk_pd_a_bit: assert property ((enable_pin && !reg_wr)[*4] ##0 !power_and_fault_mask_a_bit()
        |=> !out0_power_down)
        else $error("output a powered down while enabled and bit clear");

    // every condition masked keeps the pin released
    chk_fault_mask_all: assert property ((state.power_and_fault_mask[4:0] == 5'h1f) |=> fault_n)
        else $error("fault asserted with every condition masked");

    // first termination flag unmasked and in its active polarity
    chk_fault_term_a: assert property ((state.power_and_fault_mask[1] == 1'b0
        && (status_flags[1] ^ state.fault_polarity_select[1])) |=> !fault_n)
        else $error("unmasked termination fault did not pull fault low");

    // signal condition fires when the flag equals its polarity bit
    chk_fault_signal: assert property ((!state.power_and_fault_mask[0]
        && status_flags[0] == state.fault_polarity_select[0]) |=> !fault_n)
        else $error("unmasked signal condition did not pull fault low");

    // two quiet cycles release the pin
    chk_fault_release: assert property ((cond_active == 5'h00)[*2] |=> fault_n)
        else $error("fault held low with no active condition");

    // reserved bit never stored, whatever the host sends
    chk_rsvd_zero: assert property (s_mask_write(FMOC_OFF_POLARITY) |=> !state.fault_polarity_select[5])
        else $error("reserved polarity bit stored as one");

    // pin held high forces standard rate
    chk_rate_force: assert property ((rate_pin)[*4] |-> standard_def_rate_select)
        else $error("rate pin high did not force standard rate");

    // output-a write lands in the amplitude code and threshold upper bits
    chk_amp_write: assert property (s_mask_write(FMOC_OFF_OUT_A)
        |=> out_a_level_code == $past(reg_wdata[4:0])
        && hi_rate_threshold_a[3:1] == $past(reg_wdata[7:5]))
        else $error("output-a fields not updated by write");

    // reads: the word answered is the one stored at the read edge
    sequence s_read_from(logic [7:0] off);
        reg_rd && reg_addr == off;
    endsequence

    // an offset outside the bank; writes there are dropped, reads answer zero
    sequence s_unmapped_access;
        reg_addr != FMOC_OFF_MASK && reg_addr != FMOC_OFF_POLARITY && reg_addr != FMOC_OFF_OUT_A;
    endsequence

    // enable pin high long enough to have crossed both sync flops
    sequence s_enable_high_held;
        (enable_pin)[*4];
    endsequence

    // rate pin low long enough that only the rate bit decides
    sequence s_rate_low_held;
        (!rate_pin)[*4];
    endsequence

    // mask register read returns the stored word
    chk_read_mask: assert property (s_read_from(FMOC_OFF_MASK)
        |=> reg_rdata == $past(state.power_and_fault_mask))
        else $error("mask register read returned a wrong word");

    // polarity register read returns the stored word
    chk_read_polarity: assert property (s_read_from(FMOC_OFF_POLARITY)
        |=> reg_rdata == $past(state.fault_polarity_select))
        else $error("polarity register read returned a wrong word");

    // output-a register read returns the stored word
    chk_read_out_a: assert property (s_read_from(FMOC_OFF_OUT_A)
        |=> reg_rdata == $past(state.out0_threshold_amplitude))
        else $error("output-a register read returned a wrong word");

    // unmapped reads answer zero so software sees a hole, not a mirror
    chk_read_unmapped: assert property (reg_rd ##0 s_unmapped_access |=> reg_rdata == 8'h00)
        else $error("unmapped read returned nonzero data");

    // read data holds between reads, so a slow host may pick it up late
    chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    // writes to unmapped offsets leave every register alone
    chk_write_unmapped: assert property (reg_wr ##0 s_unmapped_access
        |=> $stable(state.power_and_fault_mask) && $stable(state.fault_polarity_select)
        && $stable(state.out0_threshold_amplitude))
        else $error("unmapped write disturbed a register");

    // registers change only on a write to their own offset
    chk_mask_hold: assert property (!(reg_wr && reg_addr == FMOC_OFF_MASK)
        |=> $stable(state.power_and_fault_mask))
        else $error("mask register changed without a write");

    chk_polarity_hold: assert property (!(reg_wr && reg_addr == FMOC_OFF_POLARITY)
        |=> $stable(state.fault_polarity_select))
        else $error("polarity register changed without a write");

    chk_out_a_hold: assert property (!(reg_wr && reg_addr == FMOC_OFF_OUT_A)
        |=> $stable(state.out0_threshold_amplitude))
        else $error("output-a register changed without a write");

    // polarity write carries the high-rate threshold low bit
    chk_thr_low_write: assert property (s_mask_write(FMOC_OFF_POLARITY)
        |=> hi_rate_threshold_a[0] == $past(reg_wdata[FMOC_BIT_HI_THR_LSB]))
        else $error("high-rate threshold low bit not taken from polarity write");

    // polarity write carries the standard-rate threshold low bit
    chk_std_low_write: assert property (s_mask_write(FMOC_OFF_POLARITY)
        |=> std_rate_threshold_a_low_bit == $past(reg_wdata[FMOC_BIT_STD_THR_LSB]))
        else $error("standard-rate threshold low bit not taken from polarity write");

    // output b follows its bit once the enable pin has settled high
    chk_pd_b_bit: assert property (s_enable_high_held ##0 !state.power_and_fault_mask[FMOC_BIT_PD_B]
        |=> !out1_power_down)
        else $error("output b powered down while enabled and bit clear");

    // a fresh enable edge cannot wake the outputs before the sync flops pass it
    chk_pd_b_sync: assert property (s_enable_low_held ##1 enable_pin
        |-> out1_power_down ##1 out1_power_down)
        else $error("output b woke before the enable pin was synchronised");

    chk_pd_a_sync: assert property (s_enable_low_held ##1 enable_pin
        |-> out0_power_down ##1 out0_power_down)
        else $error("output a woke before the enable pin was synchronised");

    // a set power-down bit always wins over an enabled pin
    chk_pd_b_set: assert property (state.power_and_fault_mask[FMOC_BIT_PD_B] |=> out1_power_down)
        else $error("output b active with its power-down bit set");

    // same for output a
    chk_pd_a_set: assert property (state.power_and_fault_mask[FMOC_BIT_PD_A] |=> out0_power_down)
        else $error("output a active with its power-down bit set");

    // rate bit alone selects standard rate
    chk_rate_bit: assert property (state.power_and_fault_mask[FMOC_BIT_RATE_SEL]
        |=> standard_def_rate_select)
        else $error("rate bit set but high rate still selected");

    // pin low and bit clear leave the high rate selected
    chk_rate_hd: assert property (s_rate_low_held ##0 !state.power_and_fault_mask[FMOC_BIT_RATE_SEL]
        |=> !standard_def_rate_select)
        else $error("standard rate selected with pin low and bit clear");

    // any active condition pulls the pin on the next edge
    chk_fault_any: assert property ((|cond_active) |=> !fault_n)
        else $error("active condition left the fault pin high");

    // per termination-fault flag: active pulls the pin, alone unmasked and idle releases it
    genvar gc;
    generate
        for (gc = FMOC_BIT_COND_LO; gc <= FMOC_BIT_COND_HI; gc++) begin : g_term_chk
            chk_term_pull: assert property ((!state.power_and_fault_mask[gc]
                && status_flags[gc] != state.fault_polarity_select[gc]) |=> !fault_n)
                else $error("unmasked termination fault left the fault pin high");
            chk_term_quiet: assert property ((state.power_and_fault_mask[4:0] == (5'h1f ^ 5'(1 << gc))
                && status_flags[gc] == state.fault_polarity_select[gc]) |=> fault_n)
                else $error("idle termination flag pulled the fault pin low");
        end
    endgenerate

    // signal condition alone unmasked and idle keeps the pin released
    chk_signal_quiet: assert property ((state.power_and_fault_mask[4:0] == 5'h1e
        && status_flags[0] != state.fault_polarity_select[0]) |=> fault_n)
        else $error("idle signal condition pulled the fault pin low");

    function automatic logic power_and_fault_mask_a_bit();
        return state.power_and_fault_mask[FMOC_BIT_PD_A];
    endfunction

endmodule // fmoc_bank

// ---- tb/fmoc_host_model.sv ----
// host-side model: byte register port master and status flag source
`timescale 1ns/1ps
module fmoc_host_model (
    // clock
    input  wire logic       ref_clk,
    // register port
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata,
    // [4]b_neg [3]b_pos [2]a_neg [1]a_pos [0]present
    output logic      [4:0] status_flags
);
    // idle port, signal present, no faults
    initial begin
        reg_wr       = 1'b0;
        reg_rd       = 1'b0;
        reg_addr     = 8'h00;
        reg_wdata    = 8'h00;
        status_flags = 5'h01;
    end
    // one-cycle strobe; released lines invert so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_addr  = a;
        reg_wdata = (a == fmoc_pkg::FMOC_OFF_POLARITY) ? (d & 8'hdf) : d;
        reg_wr    = 1'b1;
        @(negedge ref_clk);
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~reg_wdata;
    endtask
    // status flags change here only, so the model stays their one driver
    task automatic flags(input logic [4:0] f);
        status_flags = f;
    endtask
    // data is registered at the read edge itself, then holds
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge ref_clk);
        reg_rd   = 1'b0;
        reg_addr = ~a;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask
endmodule // fmoc_host_model

// ---- tb/fault_mask_output_control_tb_top.sv ----
// testbench: defaults, fields, power gating, rate select, fault combining
`timescale 1ns/1ps
module fault_mask_output_control_tb_top;
    import fmoc_pkg::*;
    logic       ref_clk = 1'b0, rst = 1'b1, enable_pin = 1'b0, rate_pin = 1'b0;
    logic       reg_wr, reg_rd, out0_power_down, out1_power_down;
    logic       standard_def_rate_select, std_rate_threshold_a_low_bit, fault_n;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [4:0] status_flags, out_a_level_code;
    logic [3:0] hi_rate_threshold_a;
    int         errors = 0, compares = 0;

    always #5 ref_clk = ~ref_clk;

    fmoc_host_model host (.ref_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .status_flags);
    fmoc_bank dut (.ref_clk, .rst, .enable_pin, .rate_pin, .status_flags, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata, .out0_power_down, .out1_power_down, .standard_def_rate_select,
        .hi_rate_threshold_a, .std_rate_threshold_a_low_bit, .out_a_level_code, .fault_n);

    // four-state compare, so an unknown never matches
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic end_of_test();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // reset values, field routing, unmapped offset
    task automatic t_regs();
        check(8'({out1_power_down, out0_power_down}), 8'h03);
        check(8'(hi_rate_threshold_a), 8'h08);
        check(8'(out_a_level_code), 8'h10);
        host.rd(FMOC_OFF_OUT_A, d);
        check(d, 8'h90);
        host.wr(FMOC_OFF_OUT_A, 8'h55);
        host.wr(FMOC_OFF_POLARITY, 8'hc0);
        step(1);
        check(8'(hi_rate_threshold_a), 8'h05);
        check(8'(std_rate_threshold_a_low_bit), 8'h01);
        check(8'(out_a_level_code), 8'h15);
        host.rd(FMOC_OFF_POLARITY, d);
        check(d, 8'hc0);
        host.wr(8'h05, 8'hff);
        host.rd(8'h05, d);
        check(d, 8'h00);
    endtask
    // enable pin overrides the clear power-down bit of output b; each bit set alone
    task automatic t_power();
        enable_pin = 1'b1;
        step(3);
        check(8'({out1_power_down, out0_power_down}), 8'h00);
        host.wr(FMOC_OFF_MASK, 8'h40);
        step(1);
        check(8'({out1_power_down, out0_power_down}), 8'h02);
        host.wr(FMOC_OFF_MASK, 8'h20);
        step(1);
        check(8'({out1_power_down, out0_power_down}), 8'h01);
        enable_pin = 1'b0;
        step(3);
        check(8'({out1_power_down, out0_power_down}), 8'h03);
        enable_pin = 1'b1;
    endtask
    // rate bit selects standard; the pin forces it with the bit clear
    task automatic t_rate();
        host.wr(FMOC_OFF_MASK, 8'h80);
        step(1);
        check(8'(standard_def_rate_select), 8'h01);
        host.wr(FMOC_OFF_MASK, 8'h00);
        rate_pin = 1'b1;
        step(1);
        check(8'(standard_def_rate_select), 8'h00);
        step(2);
        check(8'(standard_def_rate_select), 8'h01);
        rate_pin = 1'b0;
    endtask
    task automatic fchk(input logic [4:0] f, input logic [7:0] m, input logic [7:0] p, input logic [7:0] e);
        host.wr(FMOC_OFF_MASK, m);
        host.wr(FMOC_OFF_POLARITY, p);
        host.flags(f);
        step(1);
        check(8'(fault_n), e);
    endtask
    // each condition alone: raised, masked, polarity inverted
    task automatic t_fault();
        for (int i = 0; i < 5; i++) begin
            fchk(5'h01 ^ 5'(1 << i), 8'h00, 8'h00, 8'h00);
            fchk(5'h01 ^ 5'(1 << i), 8'(1 << i), 8'h00, 8'h01);
            fchk(5'h01 ^ 5'(1 << i), 8'h00, 8'(1 << i), 8'h01);
            fchk(5'h01, 8'h00, 8'(1 << i), 8'h00);
            fchk(5'h01, 8'h1f ^ 8'(1 << i), 8'h00, 8'h01);
        end
        fchk(5'h1e, 8'h1f, 8'h00, 8'h01);
        fchk(5'h01, 8'h00, 8'h00, 8'h01);
    endtask
    initial begin
        step(2);
        rst = 1'b0;
        t_regs();
        t_power();
        t_rate();
        t_fault();
        end_of_test();
    end
endmodule // fault_mask_output_control_tb_top
